// file: inc/mac_pkg.sv
package mac_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_SRC_A  = 8'h00;
    localparam logic [7:0] REG_SRC_B  = 8'h04;
    localparam logic [7:0] REG_ACC_LO = 8'h08;
    localparam logic [7:0] REG_ACC_HI = 8'h0c;
    localparam logic [7:0] REG_CTRL   = 8'h10;
    localparam logic [7:0] REG_RES_LO = 8'h14;
    localparam logic [7:0] REG_RES_HI = 8'h18;
    localparam logic [7:0] REG_STAT   = 8'h1c;

    // Control field layout
    localparam int OP_LSB   = 0;
    localparam int OP_W     = 4;
    localparam int SHIFT_B  = 4;
    localparam int IMM_SEL_B = 5;
    localparam int IMM_LSB  = 8;
    localparam int IMM_W    = 9;
    localparam int GO_B     = 31;

    // Status bit positions
    localparam int ST_V   = 0;
    localparam int ST_SV  = 1;
    localparam int ST_AV  = 2;
    localparam int ST_SAV = 3;

    // Reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    // Arithmetic constants
    localparam logic [15:0] Q_MIN16    = 16'h8000;
    localparam logic [31:0] Q_MAX32    = 32'h7fff_ffff;
    localparam logic [31:0] Q_MIN32    = 32'h8000_0000;
    localparam logic [33:0] ROUND_HALF = 34'h0_0000_8000;
    localparam logic [31:0] HI_MASK    = 32'hffff_0000;
    localparam logic [63:0] S_MAX64    = 64'h7fff_ffff_ffff_ffff;
    localparam logic [63:0] S_MIN64    = 64'h8000_0000_0000_0000;
    localparam logic [63:0] U_MAX64    = 64'hffff_ffff_ffff_ffff;
    localparam int          HALF_SHIFT = 16;

    // Operation selector
    typedef enum logic [OP_W-1:0] {
        OP_MADD_Q   = 4'h0,
        OP_MADD_H   = 4'h1,
        OP_MADDM    = 4'h2,
        OP_MADDM_U  = 4'h3,
        OP_MADDMS   = 4'h4,
        OP_MADDMS_U = 4'h5,
        OP_MADDM_H  = 4'h6,
        OP_MADDM_Q  = 4'h7,
        OP_MADDR_H  = 4'h8,
        OP_MADDR_Q  = 4'h9,
        OP_MADDRS_H = 4'ha,
        OP_MADDRS_Q = 4'hb
    } op_t;

    // Wishbone request and response
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

endpackage

// file: logic/q_mul16.sv
`timescale 1ns/1ps
`default_nettype none
module q_mul16
    import mac_pkg::*;
(
    input  wire logic [15:0] i_a,
    input  wire logic [15:0] i_b,
    input  wire logic        i_shift,
    output logic      [31:0] o_prod
);
    logic signed [31:0] raw;

    // Signed halfword product, optionally left-justified
    always_comb begin
        raw = $signed(i_a) * $signed(i_b);
        if (i_shift && i_a == Q_MIN16 && i_b == Q_MIN16) begin
            o_prod = Q_MAX32;
        end else if (i_shift) begin
            o_prod = {raw[30:0], 1'b0};
        end else begin
            o_prod = raw;
        end
    end
endmodule
`default_nettype wire

// file: logic/round_sat.sv
`timescale 1ns/1ps
`default_nettype none
module round_sat
    import mac_pkg::*;
(
    input  wire logic [33:0] i_sum,
    input  wire logic        i_round,
    input  wire logic        i_sat,
    output logic      [31:0] o_res,
    output logic             o_v,
    output logic             o_av
);
    logic [33:0] r;
    logic [31:0] s;

    // Exact sum kept at 34 bits so rounding carry is never lost
    always_comb begin
        r = i_round ? i_sum + ROUND_HALF : i_sum;
        o_v = !(r[33:31] == 3'b000 || r[33:31] == 3'b111);
        if (i_sat && o_v) begin
            s = r[33] ? Q_MIN32 : Q_MAX32;
        end else begin
            s = r[31:0];
        end
        // Truncation after the half-LSB add
        o_res = i_round ? (s & HI_MASK) : s;
        o_av = o_res[31] ^ o_res[30];
    end
endmodule
`default_nettype wire

// file: logic/mac_unit.sv
// How it works
// - With shift one, 0x8000 times 0x8000 gives 0x7FFFFFFF, not overflow.
// - Q form: signed upper halfwords multiplied, shifted by n, added to accumulator.
// - Signed multiword: full 64-bit product added to the 64-bit accumulator pair.
// - Immediate widened to 32 bits: sign extended signed, zero extended unsigned.
// - Multiword forms other than the two halfword ones take register or immediate operand; unsigned form is unsigned.
// - Packed multiword: both halfword products summed, sign extended, shifted 16, accumulated.
// - Q multiword: upper product sign extended to 64, shifted 16, accumulated.
// - Saturating multiword: same sum, signed or unsigned saturation.
// - Saturating single results clamp to the limit on overflow.
// - Overflow comes from the exact sum, advanced overflow from the final result.
// - Packed forms other than packed multiword evaluate flags per half and combine them.
// - Packed rounding: each half sum rounded, its upper halfword to matching half.
// - Q rounding: rounded upper halfword to result top, bottom halfword zero.
// - Packed rounding saturation saturates each half on its own overflow.
// - Packed rounding saturation follows packed rounding flow with signed saturation.
// - Q rounding saturation: round, saturate, upper halfword out, lower cleared.
// - Halfword product shifted left one when shift field is one, except in the two multiword halfword forms.
// - Packed Q form writes both 32-bit half sums to the result pair.
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mac_unit
    import mac_pkg::*;
(
    input  wire logic              I_MCLK,
    input  wire logic              I_RESET,
    input  wire mac_pkg::wb_req_t  I_WB,
    output var mac_pkg::wb_rsp_t   O_WB
);
    import mac_pkg::*;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [31:0] acc_lo;
        logic [31:0] acc_hi;
        logic [31:0] ctrl;
        logic        go;
        logic [31:0] res_lo;
        logic [31:0] res_hi;
        logic        v;
        logic        sv;
        logic        av;
        logic        sticky_advance_overflow_flag;
    } state_t;

    state_t st;
    state_t next_st;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // Decoded control fields
    op_t              op;
    logic             shift_n;
    logic             imm_sel;
    logic [IMM_W-1:0] nine_bit_immediate;
    logic             q_form;
    logic             rnd;
    logic             sat16;
    logic             shift_eff;

    assign op                 = op_t'(st.ctrl[OP_LSB +: OP_W]);
    assign shift_n            = st.ctrl[SHIFT_B];
    assign imm_sel            = st.ctrl[IMM_SEL_B];
    assign nine_bit_immediate = st.ctrl[IMM_LSB +: IMM_W];

    // Forms that use one halfword product and the 32-bit accumulator
    assign q_form = (op == OP_MADD_Q) || (op == OP_MADDR_Q) ||
                    (op == OP_MADDRS_Q);
    assign rnd    = (op == OP_MADDR_H) || (op == OP_MADDR_Q) ||
                    (op == OP_MADDRS_H) || (op == OP_MADDRS_Q);
    assign sat16  = (op == OP_MADDRS_H) || (op == OP_MADDRS_Q);
    // Multiword halfword forms never left-justify
    assign shift_eff = shift_n && op != OP_MADDM_H && op != OP_MADDM_Q;

    // Halfword multipliers
    logic [31:0] prod_hi;
    logic [31:0] prod_lo;

    q_mul16 u_mul_hi (
        .i_a     (st.src_a[31:16]),
        .i_b     (st.src_b[31:16]),
        .i_shift (shift_eff),
        .o_prod  (prod_hi)
    );

    q_mul16 u_mul_lo (
        .i_a     (st.src_a[15:0]),
        .i_b     (st.src_b[15:0]),
        .i_shift (shift_eff),
        .o_prod  (prod_lo)
    );

    // Per-half accumulate, round and saturate
    logic [31:0] acc_h;
    logic [33:0] sum_hi;
    logic [33:0] sum_lo;
    logic [31:0] rh;
    logic [31:0] rl;
    logic        vh;
    logic        vl;
    logic        avh;
    logic        avl;

    assign acc_h  = q_form ? st.acc_lo : st.acc_hi;
    assign sum_hi = {{2{acc_h[31]}}, acc_h} +
                    {{2{prod_hi[31]}}, prod_hi};
    assign sum_lo = {{2{st.acc_lo[31]}}, st.acc_lo} +
                    {{2{prod_lo[31]}}, prod_lo};

    round_sat u_rs_hi (
        .i_sum   (sum_hi),
        .i_round (rnd),
        .i_sat   (sat16),
        .o_res   (rh),
        .o_v     (vh),
        .o_av    (avh)
    );

    round_sat u_rs_lo (
        .i_sum   (sum_lo),
        .i_round (rnd),
        .i_sat   (sat16),
        .o_res   (rl),
        .o_v     (vl),
        .o_av    (avl)
    );

    // Multiword datapath, two guard bits above the 64-bit sum
    logic        uns;
    logic [31:0] opb;
    logic [63:0] p64;
    logic [65:0] addend;
    logic [65:0] msum;
    logic [32:0] hsum;
    logic [63:0] acc64;
    logic        mv;
    logic [63:0] mres;

    assign uns   = (op == OP_MADDM_U) || (op == OP_MADDMS_U);
    assign acc64 = {st.acc_hi, st.acc_lo};

    always_comb begin
        // Immediate replaces the second operand
        if (imm_sel) begin
            opb = uns ? {{(32-IMM_W){1'b0}}, nine_bit_immediate}
                      : {{(32-IMM_W){nine_bit_immediate[IMM_W-1]}},
                         nine_bit_immediate};
        end else begin
            opb = st.src_b;
        end
        if (uns) begin
            p64 = 64'(st.src_a) * 64'(opb);
        end else begin
            // Widen before multiplying so the upper product word is kept
            p64 = 64'($signed(st.src_a)) * 64'($signed(opb));
        end
        hsum = {prod_hi[31], prod_hi} + {prod_lo[31], prod_lo};
        case (op)
            OP_MADDM_H: begin
                addend = 66'({{33{hsum[32]}}, hsum} << HALF_SHIFT);
            end
            OP_MADDM_Q: begin
                addend = 66'({{34{prod_hi[31]}}, prod_hi} << HALF_SHIFT);
            end
            default: begin
                addend = uns ? {2'b00, p64} : {{2{p64[63]}}, p64};
            end
        endcase
        msum = uns ? {2'b00, acc64} + addend
                   : {{2{acc64[63]}}, acc64} + addend;
        // Overflow of the 64-bit destination
        if (uns) begin
            mv = |msum[65:64];
        end else begin
            mv = !(msum[65:63] == 3'b000 || msum[65:63] == 3'b111);
        end
        mres = msum[63:0];
        if (mv && (op == OP_MADDMS || op == OP_MADDMS_U)) begin
            if (uns) begin
                mres = U_MAX64;
            end else begin
                mres = msum[65] ? S_MIN64 : S_MAX64;
            end
        end
    end

    // Result selection per operation
    logic        c_ok;
    logic [31:0] c_lo;
    logic [31:0] c_hi;
    logic        c_v;
    logic        c_av;

    always_comb begin
        c_ok = 1'b1;
        c_lo = st.res_lo;
        c_hi = st.res_hi;
        c_v  = 1'b0;
        c_av = 1'b0;
        case (op)
            OP_MADD_Q: begin
                c_lo = rh;
                c_hi = WORD_RST;
                c_v  = vh;
                c_av = avh;
            end
            OP_MADD_H: begin
                c_hi = rh;
                c_lo = rl;
                c_v  = vh | vl;
                c_av = avh | avl;
            end
            OP_MADDR_H, OP_MADDRS_H: begin
                c_lo = {rh[31:16], rl[31:16]};
                c_hi = WORD_RST;
                c_v  = vh | vl;
                c_av = avh | avl;
            end
            OP_MADDR_Q, OP_MADDRS_Q: begin
                c_lo = {rh[31:16], 16'h0000};
                c_hi = WORD_RST;
                c_v  = vh;
                c_av = avh;
            end
            OP_MADDM, OP_MADDM_U, OP_MADDMS, OP_MADDMS_U,
            OP_MADDM_H, OP_MADDM_Q: begin
                c_lo = mres[31:0];
                c_hi = mres[63:32];
                c_v  = mv;
                c_av = mres[63] ^ mres[62];
            end
            default: begin
                // Unknown selector leaves results and flags alone
                c_ok = 1'b0;
            end
        endcase
    end

    // Bus decode
    logic        take;
    logic        wr;
    logic [31:0] rd;

    assign take = I_WB.cyc && I_WB.stb && !st.ack;
    assign wr   = take && I_WB.we;

    always_comb begin
        case (I_WB.adr)
            REG_SRC_A:  rd = st.src_a;
            REG_SRC_B:  rd = st.src_b;
            REG_ACC_LO: rd = st.acc_lo;
            REG_ACC_HI: rd = st.acc_hi;
            REG_CTRL:   rd = {1'b0, st.ctrl[30:0]};
            REG_RES_LO: rd = st.res_lo;
            REG_RES_HI: rd = st.res_hi;
            REG_STAT: begin
                rd = WORD_RST;
                rd[ST_V]   = st.v;
                rd[ST_SV]  = st.sv;
                rd[ST_AV]  = st.av;
                rd[ST_SAV] = st.sticky_advance_overflow_flag;
            end
            default:    rd = WORD_RST;
        endcase
    end

    // Next-state logic
    logic clr_sv;
    logic clr_sav;
    logic set_v;
    logic set_av;

    always_comb begin
        next_st = st;
        next_st.ack = take;
        next_st.go  = 1'b0;
        if (take) begin
            next_st.rdat = rd;
        end
        clr_sv  = 1'b0;
        clr_sav = 1'b0;
        if (wr) begin
            case (I_WB.adr)
                REG_SRC_A:  next_st.src_a  = merge(st.src_a, I_WB.dat, I_WB.sel);
                REG_SRC_B:  next_st.src_b  = merge(st.src_b, I_WB.dat, I_WB.sel);
                REG_ACC_LO: next_st.acc_lo = merge(st.acc_lo, I_WB.dat, I_WB.sel);
                REG_ACC_HI: next_st.acc_hi = merge(st.acc_hi, I_WB.dat, I_WB.sel);
                REG_CTRL: begin
                    next_st.ctrl = merge(st.ctrl, I_WB.dat, I_WB.sel);
                    next_st.ctrl[GO_B] = 1'b0;
                    next_st.go = I_WB.sel[3] && I_WB.dat[GO_B];
                end
                REG_STAT: begin
                    // Write one to clear a sticky bit
                    clr_sv  = I_WB.sel[0] && I_WB.dat[ST_SV];
                    clr_sav = I_WB.sel[0] && I_WB.dat[ST_SAV];
                end
                default: begin
                end
            endcase
        end
        // Execute one cycle after the starting write
        set_v  = st.go && c_ok && c_v;
        set_av = st.go && c_ok && c_av;
        if (st.go && c_ok) begin
            next_st.res_lo = c_lo;
            next_st.res_hi = c_hi;
            next_st.v  = c_v;
            next_st.av = c_av;
        end
        // A set in the clearing cycle wins
        next_st.sv  = (st.sv && !clr_sv) || set_v;
        next_st.sticky_advance_overflow_flag = (st.sticky_advance_overflow_flag && !clr_sav) || set_av;
    end

    // State register
    always_ff @(posedge I_MCLK) begin
        if (I_RESET) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign O_WB.ack = st.ack;
    assign O_WB.dat = st.rdat;
endmodule
`default_nettype wire

// file: sim/mac_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mac_unit_checker
    import mac_pkg::*;
(
    input wire logic             I_MCLK,
    input wire logic             I_RESET,
    input wire mac_pkg::wb_req_t I_WB,
    input wire mac_pkg::wb_rsp_t O_WB
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);

    // Request seen with no answer pending
    sequence s_take;
        I_WB.cyc && I_WB.stb && !O_WB.ack;
    endsequence

    // Answer to a read of one address
    sequence s_read(logic [7:0] a);
        O_WB.ack && !I_WB.we && I_WB.adr == a;
    endsequence

    AST_ACK_TAKEN: assert property (s_take |=> O_WB.ack) else $error("no ack after request");
    AST_ACK_PULSE: assert property (O_WB.ack |=> !O_WB.ack) else $error("ack held too long");
    AST_ACK_CAUSE: assert property (O_WB.ack |-> $past(I_WB.cyc && I_WB.stb)) else $error("ack without request");
    // Checked through reset, so it carries its own empty disable
    AST_RESET_QUIET: assert property (disable iff (1'b0) I_RESET |=> !O_WB.ack && O_WB.dat == 32'h0)
        else $error("bus active after reset");
    AST_GO_READ: assert property (s_read(REG_CTRL) |-> !O_WB.dat[GO_B]) else $error("go bit read back");
    AST_UNMAPPED: assert property (O_WB.ack && !I_WB.we && I_WB.adr > REG_STAT |-> O_WB.dat == 32'h0)
        else $error("unmapped read not zero");
    AST_STICKY_V: assert property (s_read(REG_STAT) |-> !O_WB.dat[ST_V] || O_WB.dat[ST_SV])
        else $error("sticky overflow missing");
    AST_STICKY_AV: assert property (s_read(REG_STAT) |-> !O_WB.dat[ST_AV] || O_WB.dat[ST_SAV])
        else $error("sticky advance overflow missing");
endmodule

bind mac_unit mac_unit_checker chk_u (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_WB(I_WB), .O_WB(O_WB));
`default_nettype wire

// file: sim/wb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module wb_host_model
    import mac_pkg::*;
(
    input  wire logic             i_clk,
    input  wire mac_pkg::wb_rsp_t i_rsp,
    output var mac_pkg::wb_req_t  o_req
);
    initial o_req = '0;

    // One classic cycle; released lines show inverted leftovers, never stale values
    // Waits for ack however long it takes; late flags an answer off the one-cycle slot
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
            input logic [3:0] sel, output logic [31:0] rdat, output logic late);
        int n;
        n = 0;
        @(posedge i_clk);
        o_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
        do begin
            @(posedge i_clk);
            n++;
        end while (i_rsp.ack !== 1'b1);
        rdat = i_rsp.dat;
        late = n != 2;
        o_req <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: ~sel, dat: ~dat};
    endtask
endmodule
`default_nettype wire

// file: sim/mac_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module mac_unit_test;
    import mac_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    wb_req_t     req;
    wb_rsp_t     rsp;
    logic [31:0] rdat;
    logic [31:0] last_lo;
    logic        sv = 1'b0;
    logic        sticky_advance_overflow_flag = 1'b0;
    logic        late;
    int          mismatches = 0;
    int          num_checks = 0;
    int          seed = 64;

    mac_unit dut_u (.I_MCLK(mclk), .I_RESET(rst), .I_WB(req), .O_WB(rsp));
    wb_host_model host_u (.i_clk(mclk), .i_rsp(rsp), .o_req(req));

    // 20 MHz clock
    always #25 mclk = ~mclk;

    function automatic logic ov(input logic signed [65:0] x);
        return x != $signed(x[31:0]);
    endfunction

    // Clamp to 32 bits only when asked
    function automatic logic [31:0] sat(input logic signed [65:0] x, input logic en);
        return (en && ov(x)) ? (x[65] ? Q_MIN32 : Q_MAX32) : x[31:0];
    endfunction

    // Expected {V, AV, result pair}; wide sums so nothing wraps before it is judged
    function automatic logic [65:0] model(input logic [3:0] op, input logic n, im, input logic [8:0] k,
            input logic [31:0] a, b, input logic [63:0] acc);
        logic signed [65:0] ph, pl, qh, ql, s, t, u, rnd;
        logic [31:0]        bb, hs, ls;
        logic [63:0]        r;
        logic               v, av;
        ph = $signed(a[31:16]) * $signed(b[31:16]);
        pl = $signed(a[15:0]) * $signed(b[15:0]);
        qh = (n && a[31:16] == Q_MIN16 && b[31:16] == Q_MIN16) ? 66'sh7fff_ffff : ph <<< n;
        ql = (n && a[15:0] == Q_MIN16 && b[15:0] == Q_MIN16) ? 66'sh7fff_ffff : pl <<< n;
        rnd = op[3] ? 66'sh8000 : 66'sh0;
        s = $signed(acc[63:32]) + qh + rnd;
        t = $signed(acc[31:0]) + ql + rnd;
        u = $signed(acc[31:0]) + qh + rnd;
        bb = !im ? b : op[0] ? {23'h0, k} : {{23{k[8]}}, k};
        hs = sat(s, op[1]);
        ls = sat(t, op[1]);
        case (op)
            4'h0, 4'h9, 4'hb: begin
                hs = sat(u, op[1]);
                r = op[3] ? {32'h0, hs[31:16], 16'h0} : {32'h0, u[31:0]};
                v = ov(u);
                av = hs[31] ^ hs[30];
            end
            4'h1, 4'h8, 4'ha: begin
                r = op[3] ? {32'h0, hs[31:16], ls[31:16]} : {s[31:0], t[31:0]};
                v = ov(s) | ov(t);
                av = hs[31] ^ hs[30] | ls[31] ^ ls[30];
            end
            default: begin
                if (op == 4'h6) s = $signed(acc) + ((ph + pl) <<< 16);
                else if (op == 4'h7) s = $signed(acc) + (ph <<< 16);
                else if (op[0]) s = acc + a * bb;
                else s = $signed(acc) + $signed(a) * $signed(bb);
                v = (op[0] && op < 4'h6) ? s[64] : s[64] != s[63];
                r = (!v || op < 4'h4 || op > 4'h5) ? s[63:0] : op[0] ? U_MAX64 : s[65] ? S_MIN64 : S_MAX64;
                av = r[63] ^ r[62];
            end
        endcase
        return {v, av, r};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One register access; a late answer counts as a mismatch
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        host_u.xfer(we, adr, dat, sel, rdat, late);
        if (late === 1'b1) chk(64'h0, 64'h1);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0, 4'hf);
        chk(64'(rdat), 64'(exp));
    endtask

    // Load operands, start, then read result pair and flags
    task automatic run_op(input logic [3:0] op, input logic n, im, input logic [8:0] k,
            input logic [31:0] a, b, input logic [63:0] acc);
        logic [65:0] e;
        e = model(op, n, im, k, a, b, acc);
        sv = sv | e[65];
        sticky_advance_overflow_flag = sticky_advance_overflow_flag | e[64];
        last_lo = e[31:0];
        bus(1'b1, REG_SRC_A, a, 4'hf);
        bus(1'b1, REG_SRC_B, b, 4'hf);
        bus(1'b1, REG_ACC_LO, acc[31:0], 4'hf);
        bus(1'b1, REG_ACC_HI, acc[63:32], 4'hf);
        bus(1'b1, REG_CTRL, {1'b1, 14'h0, k, 2'h0, im, n, op}, 4'hf);
        rd(REG_RES_LO, e[31:0]);
        rd(REG_RES_HI, e[63:32]);
        bus(1'b0, REG_STAT, 32'h0, 4'hf);
        chk(64'(rdat[3:0]), 64'({sticky_advance_overflow_flag, e[64], sv, e[65]}));
        if (op inside {4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'h8, 4'h9}) chk(64'(rdat[2]), 64'(e[64]));
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #1000000;
        mismatches++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i <= 8; i++) rd(8'(i * 4), 32'h0);
        // Read-only and unmapped writes are dropped; byte lanes merge
        bus(1'b1, REG_RES_LO, 32'hffff_ffff, 4'hf);
        bus(1'b1, 8'h20, 32'hffff_ffff, 4'hf);
        rd(REG_RES_LO, 32'h0);
        rd(8'h20, 32'h0);
        bus(1'b1, REG_SRC_A, 32'h1122_3344, 4'hf);
        bus(1'b1, REG_SRC_A, 32'haabb_ccdd, 4'h1);
        rd(REG_SRC_A, 32'h1122_33dd);
        // Corner operands
        run_op(4'h0, 1'b1, 1'b0, 9'h0, 32'h8000_0000, 32'h8000_0000, 64'h0);
        run_op(4'hb, 1'b1, 1'b0, 9'h0, 32'h8000_1234, 32'h8000_5678, 64'h0);
        run_op(4'ha, 1'b0, 1'b0, 9'h0, 32'h7fff_0001, 32'h7fff_0001, 64'h7fff_0000_0000_0000);
        run_op(4'h4, 1'b0, 1'b0, 9'h0, 32'h7fff_ffff, 32'h7fff_ffff, S_MAX64);
        run_op(4'h5, 1'b0, 1'b0, 9'h0, 32'hffff_ffff, 32'hffff_ffff, U_MAX64);
        run_op(4'h2, 1'b0, 1'b1, 9'h1ff, 32'h3, 32'h0, 64'h0);
        run_op(4'h3, 1'b0, 1'b1, 9'h1ff, 32'h3, 32'h0, 64'h0);
        // Software clears both sticky flags
        bus(1'b1, REG_STAT, 32'h0000_000a, 4'h1);
        sv = 1'b0;
        sticky_advance_overflow_flag = 1'b0;
        bus(1'b0, REG_STAT, 32'h0, 4'hf);
        chk(64'({rdat[ST_SAV], rdat[ST_SV]}), 64'h0);
        for (int i = 0; i < 96; i++) begin
            run_op(4'(i % 12), 1'($random(seed)), 1'($random(seed)), 9'($random(seed)), $random(seed),
                $random(seed), {$random(seed), $random(seed)});
        end
        // Unknown operation leaves results alone; second reset clears them
        bus(1'b1, REG_CTRL, 32'h8000_000c, 4'hf);
        rd(REG_RES_LO, last_lo);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        rd(REG_RES_LO, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
